// File: core/bft_pkg.sv
// package: constants and carrier types for the branch, flag and trap unit
package bft_pkg;
    localparam int XLEN = 32;
    localparam int IMM_W = 16;
    localparam logic [1:0] ALIGN_ZERO = 2'b00;
    localparam int FIELD_W = 4;
    // jump_options bit positions, msb-first numbering mapped to lsb index
    localparam int JO_NO_LOOP = 2;
    localparam int JO_NO_COND = 4;
    localparam int JO_TRUE = 3;
    localparam int JO_LOOP_ZERO = 1;
    // trap_cond_mask bits: lt, gt, eq, ult, ugt (msb first)
    localparam int TM_LT = 4;
    localparam int TM_GT = 3;
    localparam int TM_EQ = 2;
    localparam int TM_ULT = 1;
    localparam int TM_UGT = 0;
    localparam logic [31:0] PC_RESET = 32'h0000_0000;
    localparam logic [31:0] FLAG_RESET = 32'h0000_0000;
    localparam logic [31:0] LOOP_RESET = 32'h0000_0000;
    localparam logic [31:0] RET_RESET = 32'h0000_0000;
    localparam logic [31:0] WORD_STEP = 32'h0000_0004;

    typedef enum logic [4:0] {
        OP_NONE, OP_JUMP_REL, OP_JUMP_ABS, OP_COND_REL, OP_COND_ABS, OP_COND_RET, OP_COND_LOOP,
        OP_FLAG_AND, OP_FLAG_OR, OP_FLAG_XOR, OP_FLAG_NAND, OP_FLAG_NOR, OP_FLAG_EQUIV,
        OP_FLAG_AND_NOT, OP_FLAG_OR_NOT, OP_FIELD_COPY, OP_TRAP_IMM, OP_TRAP_REG
    } bft_op_t;

    typedef struct packed {
        bft_op_t op;
        logic link;
        logic [31:0] pc;
        logic [31:0] target_imm;
        logic [4:0] jump_options;
        logic [4:0] cond_flag_sel;
        logic [4:0] src_flag_a;
        logic [4:0] src_flag_b;
        logic [4:0] dst_flag;
        logic [2:0] src_field;
        logic [2:0] dst_field;
        logic [4:0] trap_cond_mask;
        logic [15:0] signed_imm;
        logic [31:0] gpr_a;
        logic [31:0] gpr_b;
    } bft_instr_t;
endpackage : bft_pkg

// File: core/bft_unit.sv
// module: branch, condition-flag and trap execution unit
`timescale 1ns/1ps
// Behaviour
// - relative jump target is displacement plus own instruction address
// - absolute jump forms use the immediate directly as target
// - linking forms write next sequential address into return register
// - conditional jumps test selected flag bit under jump options
// - return-register target uses bits 0 to 29, low bits zero
// - loop-register target uses bits 0 to 29, low bits zero
// - linking return-jump uses old return value, then writes link
// - loop-register jump with decrement requested is an invalid form
// - flag logic or field copy with link set is invalid
// - and, or, xor of two flag bits into destination bit
// - nand, nor, equiv write inverted and, or, xor result
// - and-not, or-not combine first bit with inverted second
// - field copy moves one 4-bit field, others unchanged
// - immediate trap compares gpr_a with sign-extended immediate
// - register trap compares gpr_a with gpr_b
// - trap when any enabled mask condition is met
// - no enabled condition met: no trap, continue sequentially
// - options choose loop test, flag sense, or always
// - whole loop register decremented before zero test
// - cond_flag_sel picks one of 32 flag bits
// - link written even when conditional jump not taken
module bft_unit (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic ISSUE,
    input wire bft_pkg::bft_instr_t INSTR,
    output logic DONE,
    output logic [31:0] NEXT_PC,
    output logic TRAP,
    output logic [31:0] TRAP_PC,
    output logic INVALID,
    output logic [31:0] FLAG_REG,
    output logic [31:0] RETURN_REG,
    output logic [31:0] LOOP_REG
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] word_align(input logic [31:0] v);
        word_align = {v[31:2], bft_pkg::ALIGN_ZERO};
    endfunction : word_align

    // flag number 0 is the msb of the flag register
    function automatic logic flag_bit(input logic [31:0] f, input logic [4:0] sel);
        flag_bit = f[5'd31 - sel];
    endfunction : flag_bit

    logic [31:0] flag_q;
    logic [31:0] ret_q;
    logic [31:0] loop_q;
    logic halted_q;

    bft_pkg::bft_op_t op;
    logic is_cond;
    logic is_flag;
    logic invalid_d;
    logic take_d;
    logic loop_dec;
    logic [31:0] loop_d;
    logic [31:0] seq_pc;
    logic [31:0] target;
    logic [31:0] cmp_b;
    logic trap_d;
    logic res_bit;
    logic [31:0] flag_d;
    logic fa;
    logic fb;
    logic [4:0] jo;

    // ----------------------------------------
    // decode and evaluate
    // ----------------------------------------
    always_comb begin
        op = INSTR.op;
        jo = INSTR.jump_options;
        seq_pc = INSTR.pc + bft_pkg::WORD_STEP;
        is_cond = (op == bft_pkg::OP_COND_REL) || (op == bft_pkg::OP_COND_ABS) ||
                  (op == bft_pkg::OP_COND_RET) || (op == bft_pkg::OP_COND_LOOP);
        is_flag = (op >= bft_pkg::OP_FLAG_AND) && (op <= bft_pkg::OP_FIELD_COPY);
        invalid_d = ((op == bft_pkg::OP_COND_LOOP) && !jo[bft_pkg::JO_NO_LOOP]) ||
                    (is_flag && INSTR.link);
        loop_dec = is_cond && !jo[bft_pkg::JO_NO_LOOP] && !invalid_d;
        loop_d = loop_q - 32'h0000_0001;
        take_d = 1'b1;
        if (!jo[bft_pkg::JO_NO_LOOP]) begin
            take_d = (loop_d == 32'h0000_0000) == jo[bft_pkg::JO_LOOP_ZERO];
        end
        if (!jo[bft_pkg::JO_NO_COND]) begin
            take_d = take_d && (flag_bit(flag_q, INSTR.cond_flag_sel) == jo[bft_pkg::JO_TRUE]);
        end
        case (op)
            bft_pkg::OP_JUMP_REL, bft_pkg::OP_COND_REL: target = INSTR.pc + INSTR.target_imm;
            bft_pkg::OP_JUMP_ABS, bft_pkg::OP_COND_ABS: target = INSTR.target_imm;
            bft_pkg::OP_COND_RET: target = word_align(ret_q);
            bft_pkg::OP_COND_LOOP: target = word_align(loop_q);
            default: target = seq_pc;
        endcase
        if (!is_cond) begin
            take_d = (op == bft_pkg::OP_JUMP_REL) || (op == bft_pkg::OP_JUMP_ABS);
        end
        cmp_b = (op == bft_pkg::OP_TRAP_IMM) ? {{(bft_pkg::XLEN - bft_pkg::IMM_W){INSTR.signed_imm[bft_pkg::IMM_W - 1]}},
                INSTR.signed_imm} : INSTR.gpr_b;
        trap_d = ((op == bft_pkg::OP_TRAP_IMM) || (op == bft_pkg::OP_TRAP_REG)) && (
            (INSTR.trap_cond_mask[bft_pkg::TM_LT] && ($signed(INSTR.gpr_a) < $signed(cmp_b))) ||
            (INSTR.trap_cond_mask[bft_pkg::TM_GT] && ($signed(INSTR.gpr_a) > $signed(cmp_b))) ||
            (INSTR.trap_cond_mask[bft_pkg::TM_EQ] && (INSTR.gpr_a == cmp_b)) ||
            (INSTR.trap_cond_mask[bft_pkg::TM_ULT] && (INSTR.gpr_a < cmp_b)) ||
            (INSTR.trap_cond_mask[bft_pkg::TM_UGT] && (INSTR.gpr_a > cmp_b)));
        fa = flag_bit(flag_q, INSTR.src_flag_a);
        fb = flag_bit(flag_q, INSTR.src_flag_b);
        case (op)
            bft_pkg::OP_FLAG_AND: res_bit = fa & fb;
            bft_pkg::OP_FLAG_OR: res_bit = fa | fb;
            bft_pkg::OP_FLAG_XOR: res_bit = fa ^ fb;
            bft_pkg::OP_FLAG_NAND: res_bit = ~(fa & fb);
            bft_pkg::OP_FLAG_NOR: res_bit = ~(fa | fb);
            bft_pkg::OP_FLAG_EQUIV: res_bit = ~(fa ^ fb);
            bft_pkg::OP_FLAG_AND_NOT: res_bit = fa & ~fb;
            bft_pkg::OP_FLAG_OR_NOT: res_bit = fa | ~fb;
            default: res_bit = 1'b0;
        endcase
        flag_d = flag_q;
        if (op == bft_pkg::OP_FIELD_COPY) begin
            flag_d[(3'd7 - INSTR.dst_field) * bft_pkg::FIELD_W +: bft_pkg::FIELD_W] =
                flag_q[(3'd7 - INSTR.src_field) * bft_pkg::FIELD_W +: bft_pkg::FIELD_W];
        end else begin
            flag_d[5'd31 - INSTR.dst_flag] = res_bit;
        end
    end

    // ----------------------------------------
    // architectural registers
    // ----------------------------------------
    always_ff @(posedge MCLK) begin
        if (RST) begin
            flag_q <= bft_pkg::FLAG_RESET;
        end else if (ISSUE && !halted_q && is_flag && !invalid_d) begin
            flag_q <= flag_d;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            ret_q <= bft_pkg::RET_RESET;
        end else if (ISSUE && !halted_q && !invalid_d && INSTR.link && (is_cond || take_d)) begin
            ret_q <= seq_pc;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            loop_q <= bft_pkg::LOOP_RESET;
        end else if (ISSUE && !halted_q && loop_dec) begin
            loop_q <= loop_d;
        end
    end

    // ----------------------------------------
    // result outputs and trap hold
    // ----------------------------------------
    always_ff @(posedge MCLK) begin
        if (RST) begin
            DONE <= 1'b0;
            NEXT_PC <= bft_pkg::PC_RESET;
            TRAP <= 1'b0;
            TRAP_PC <= bft_pkg::PC_RESET;
            INVALID <= 1'b0;
            halted_q <= 1'b0;
        end else begin
            DONE <= ISSUE && !halted_q;
            TRAP <= 1'b0;
            INVALID <= 1'b0;
            if (ISSUE && !halted_q) begin
                INVALID <= invalid_d;
                NEXT_PC <= (take_d && !invalid_d) ? target : seq_pc;
                if (trap_d) begin
                    TRAP <= 1'b1;
                    TRAP_PC <= INSTR.pc;
                    NEXT_PC <= INSTR.pc;
                    halted_q <= 1'b1;
                end
            end
        end
    end

    assign FLAG_REG = flag_q;
    assign RETURN_REG = ret_q;
    assign LOOP_REG = loop_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_rel_target;
        @(posedge MCLK) disable iff (RST)
        (ISSUE && !halted_q && INSTR.op == bft_pkg::OP_JUMP_REL) |=> NEXT_PC == $past(INSTR.pc + INSTR.target_imm);
    endproperty
    a_rel_target: assert property (p_rel_target) else $error("relative target wrong");

    property p_abs_target;
        @(posedge MCLK) disable iff (RST)
        (ISSUE && !halted_q && INSTR.op == bft_pkg::OP_JUMP_ABS) |=> NEXT_PC == $past(INSTR.target_imm);
    endproperty
    a_abs_target: assert property (p_abs_target) else $error("absolute target wrong");

    property p_link;
        @(posedge MCLK) disable iff (RST)
        (ISSUE && !halted_q && is_cond && INSTR.link && !invalid_d) |=> RETURN_REG == $past(INSTR.pc) + bft_pkg::WORD_STEP;
    endproperty
    a_link: assert property (p_link) else $error("link not written");

    property p_ret_target;
        @(posedge MCLK) disable iff (RST)
        (ISSUE && !halted_q && op == bft_pkg::OP_COND_RET && take_d) |=> NEXT_PC == {$past(ret_q[31:2]), bft_pkg::ALIGN_ZERO};
    endproperty
    a_ret_target: assert property (p_ret_target) else $error("return target wrong");

    property p_invalid_loop;
        @(posedge MCLK) disable iff (RST)
        (ISSUE && !halted_q && op == bft_pkg::OP_COND_LOOP && !jo[bft_pkg::JO_NO_LOOP]) |=> INVALID && $stable(LOOP_REG);
    endproperty
    a_invalid_loop: assert property (p_invalid_loop) else $error("invalid loop form missed");

    property p_invalid_flag;
        @(posedge MCLK) disable iff (RST)
        (ISSUE && !halted_q && is_flag && INSTR.link) |=> INVALID && $stable(FLAG_REG);
    endproperty
    a_invalid_flag: assert property (p_invalid_flag) else $error("invalid flag form missed");

    property p_trap_eq;
        @(posedge MCLK) disable iff (RST)
        (ISSUE && !halted_q && op == bft_pkg::OP_TRAP_REG && INSTR.trap_cond_mask == 5'h04 &&
         INSTR.gpr_a == INSTR.gpr_b) |=> TRAP && TRAP_PC == $past(INSTR.pc);
    endproperty
    a_trap_eq: assert property (p_trap_eq) else $error("trap not raised");

    property p_no_trap;
        @(posedge MCLK) disable iff (RST)
        (ISSUE && !halted_q && op == bft_pkg::OP_TRAP_REG && INSTR.trap_cond_mask == 5'h00)
        |=> !TRAP && NEXT_PC == $past(INSTR.pc) + bft_pkg::WORD_STEP;
    endproperty
    a_no_trap: assert property (p_no_trap) else $error("spurious trap");

    property p_loop_dec;
        @(posedge MCLK) disable iff (RST)
        (ISSUE && !halted_q && op == bft_pkg::OP_COND_REL && !jo[bft_pkg::JO_NO_LOOP])
        |=> LOOP_REG == $past(LOOP_REG) - 32'h0000_0001;
    endproperty
    a_loop_dec: assert property (p_loop_dec) else $error("loop not decremented");

    property p_precise;
        @(posedge MCLK) disable iff (RST)
        TRAP |=> $stable(FLAG_REG) && $stable(RETURN_REG) && $stable(LOOP_REG) && !DONE;
    endproperty
    a_precise: assert property (p_precise) else $error("state changed after trap");

    c_trap: cover property (@(posedge MCLK) disable iff (RST) TRAP);
    c_taken_cond: cover property (@(posedge MCLK) disable iff (RST) ISSUE && is_cond && take_d);
    c_field_copy: cover property (@(posedge MCLK) disable iff (RST) ISSUE && op == bft_pkg::OP_FIELD_COPY);
    c_invalid: cover property (@(posedge MCLK) disable iff (RST) INVALID);
endmodule : bft_unit

// File: tb/bft_unit_test.sv
// testbench: corner and random instructions for the branch, flag and trap unit
`timescale 1ns/1ps
module bft_unit_test;
    logic MCLK = 1'b0;
    logic RST = 1'b1;
    logic ISSUE = 1'b0;
    bft_pkg::bft_instr_t INSTR = '0;
    logic DONE, TRAP, INVALID;
    logic [31:0] NEXT_PC, TRAP_PC, FLAG_REG, RETURN_REG, LOOP_REG;
    logic [31:0] m_pc = '0, m_tpc = '0, m_flag = '0, m_ret = '0, m_loop = '0;
    logic e_done = 1'b0, e_trap = 1'b0, e_inv = 1'b0, halted = 1'b0;
    int error_cnt = 0;
    int n_checks = 0;
    int cyc = 0;
    bft_pkg::bft_instr_t ins;
    bft_pkg::bft_op_t jop[7] = '{bft_pkg::OP_JUMP_REL, bft_pkg::OP_JUMP_ABS, bft_pkg::OP_COND_RET,
        bft_pkg::OP_COND_REL, bft_pkg::OP_COND_ABS, bft_pkg::OP_COND_LOOP, bft_pkg::OP_COND_LOOP};
    logic [4:0] jot[7] = '{5'h14, 5'h14, 5'h14, 5'h10, 5'h12, 5'h14, 5'h10};
    logic [4:0] tmt[8] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01, 5'h11, 5'h04, 5'h04};
    logic [31:0] tat[8] = '{32'hffff_ffff, 32'h1, 32'hffff_fff0, 32'h1, 32'hffff_ffff, 32'h1, 32'h0000_fff0,
        32'h8000_0000};
    logic [31:0] tbt[8] = '{32'h1, 32'hffff_ffff, 32'h0, 32'hffff_ffff, 32'h1, 32'hffff_ffff, 32'h0, 32'h8000_0000};

    bft_unit bft_unit_inst (.MCLK(MCLK), .RST(RST), .ISSUE(ISSUE), .INSTR(INSTR), .DONE(DONE),
        .NEXT_PC(NEXT_PC), .TRAP(TRAP), .TRAP_PC(TRAP_PC), .INVALID(INVALID), .FLAG_REG(FLAG_REG),
        .RETURN_REG(RETURN_REG), .LOOP_REG(LOOP_REG));

    initial begin
        forever #5 MCLK = ~MCLK;
    end

    always @(posedge MCLK) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt = error_cnt + 1;
            final_report();
        end
    end

    task automatic final_report();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report

    // ----------------------------------------
    // checks and expectations
    // ----------------------------------------
    task automatic chk_b(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : chk_b

    task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : chk_w

    task automatic check_all();
        chk_b(DONE, e_done);
        chk_b(TRAP, e_trap);
        chk_b(INVALID, e_inv);
        chk_w(NEXT_PC, m_pc);
        chk_w(TRAP_PC, m_tpc);
        chk_w(FLAG_REG, m_flag);
        chk_w(RETURN_REG, m_ret);
        chk_w(LOOP_REG, m_loop);
    endtask : check_all

    function automatic logic f_take(input logic [4:0] jo, input logic fb, input logic [31:0] ld);
        return (jo[4] | (fb == jo[3])) & (jo[2] | ((ld == 32'h0) == jo[1]));
    endfunction : f_take

    function automatic logic f_trap(input logic [4:0] tm, input logic [31:0] a, input logic [31:0] b);
        return (tm[4] & ($signed(a) < $signed(b))) | (tm[3] & ($signed(a) > $signed(b)))
            | (tm[2] & (a == b)) | (tm[1] & (a < b)) | (tm[0] & (a > b));
    endfunction : f_trap

    task automatic model(input bft_pkg::bft_instr_t i);
        logic [31:0] seq, tgt, ld, f, b;
        logic x, y;
        seq = i.pc + 32'h4;
        ld = m_loop - 32'h1;
        f = m_flag;
        x = f[31 - i.src_flag_a];
        y = f[31 - i.src_flag_b];
        b = (i.op == bft_pkg::OP_TRAP_IMM) ? {{16{i.signed_imm[15]}}, i.signed_imm} : i.gpr_b;
        tgt = (i.op == bft_pkg::OP_COND_REL || i.op == bft_pkg::OP_JUMP_REL) ? i.pc + i.target_imm :
            (i.op == bft_pkg::OP_COND_RET) ? {m_ret[31:2], 2'b00} :
            (i.op == bft_pkg::OP_COND_LOOP) ? {m_loop[31:2], 2'b00} : i.target_imm;
        m_pc = seq;
        if (i.op == bft_pkg::OP_NONE) begin
            m_pc = seq;
        end else if (i.op <= bft_pkg::OP_JUMP_ABS) begin
            m_pc = tgt;
            m_ret = i.link ? seq : m_ret;
        end else if (i.op >= bft_pkg::OP_TRAP_IMM) begin
            if (f_trap(i.trap_cond_mask, i.gpr_a, b)) begin
                e_trap = 1'b1;
                halted = 1'b1;
                m_pc = i.pc;
                m_tpc = i.pc;
            end
        end else if ((i.op == bft_pkg::OP_COND_LOOP && !i.jump_options[2]) || (i.op > 6 && i.link)) begin
            e_inv = 1'b1;
        end else if (i.op <= bft_pkg::OP_COND_LOOP) begin
            m_pc = f_take(i.jump_options, f[31 - i.cond_flag_sel], ld) ? tgt : seq;
            m_loop = i.jump_options[2] ? m_loop : ld;
            m_ret = i.link ? seq : m_ret;
        end else begin
            case (i.op)
                bft_pkg::OP_FLAG_AND: f[31 - i.dst_flag] = x & y;
                bft_pkg::OP_FLAG_OR: f[31 - i.dst_flag] = x | y;
                bft_pkg::OP_FLAG_XOR: f[31 - i.dst_flag] = x ^ y;
                bft_pkg::OP_FLAG_NAND: f[31 - i.dst_flag] = ~(x & y);
                bft_pkg::OP_FLAG_NOR: f[31 - i.dst_flag] = ~(x | y);
                bft_pkg::OP_FLAG_EQUIV: f[31 - i.dst_flag] = ~(x ^ y);
                bft_pkg::OP_FLAG_AND_NOT: f[31 - i.dst_flag] = x & ~y;
                bft_pkg::OP_FLAG_OR_NOT: f[31 - i.dst_flag] = x | ~y;
                default: f[31 - 4 * i.dst_field -: 4] = m_flag[31 - 4 * i.src_field -: 4];
            endcase
            m_flag = f;
        end
    endtask : model

    task automatic drive(input logic go, input bft_pkg::bft_instr_t i);
        @(negedge MCLK);
        check_all();
        ISSUE = go;
        INSTR = i;
        e_done = go & ~halted;
        e_trap = 1'b0;
        e_inv = 1'b0;
        if (go && !halted) begin
            model(i);
        end
    endtask : drive

    task automatic do_reset();
        @(negedge MCLK);
        check_all();
        RST = 1'b1;
        ISSUE = 1'b0;
        repeat (6) @(negedge MCLK);
        RST = 1'b0;
        {m_pc, m_tpc, m_flag, m_ret, m_loop} = '0;
        {e_done, e_trap, e_inv, halted} = '0;
    endtask : do_reset

    function automatic bft_pkg::bft_instr_t rnd();
        logic [191:0] v;
        bft_pkg::bft_instr_t i;
        v = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
        i = v[$bits(i)-1:0];
        i.op = bft_pkg::bft_op_t'(5'($urandom % 18));
        i.link = ($urandom % 4 == 0);
        i.trap_cond_mask = i.trap_cond_mask & {5{$urandom % 3 == 0}};
        i.gpr_b = ($urandom % 2) ? i.gpr_a : i.gpr_b;
        return i;
    endfunction : rnd

    // ----------------------------------------
    // stimulus
    // ----------------------------------------
    initial begin
        void'($urandom(32'h3d7c6d06));
        do_reset();
        for (int k = 0; k < 18; k++) begin
            ins = '0;
            ins.op = bft_pkg::bft_op_t'(5'(7 + k % 9));
            ins.src_flag_a = 5'(k);
            ins.src_flag_b = 5'(k + 3);
            ins.dst_flag = 5'(k * 7);
            ins.src_field = 3'(k);
            ins.dst_field = 3'(k + 2);
            drive(1'b1, ins);
            ins.link = 1'b1;
            drive(1'b1, ins);
        end
        for (int k = 0; k < 11; k++) begin
            ins = '0;
            ins.op = (k < 7) ? jop[k] : bft_pkg::OP_COND_ABS;
            ins.link = (k < 7);
            ins.pc = 32'h0000_2006;
            ins.target_imm = 32'hffff_fff0;
            ins.jump_options = (k < 7) ? jot[k] : (k[0] ? 5'h0c : 5'h04);
            ins.cond_flag_sel = 5'(k * 9);
            drive(1'b1, ins);
        end
        for (int t = 0; t < 8; t++) begin
            ins = '0;
            ins.op = (t == 2 || t == 6) ? bft_pkg::OP_TRAP_IMM : bft_pkg::OP_TRAP_REG;
            ins.pc = 32'h0000_3000;
            ins.trap_cond_mask = tmt[t];
            ins.gpr_a = tat[t];
            ins.gpr_b = tbt[t];
            ins.signed_imm = 16'hfff0;
            drive(1'b1, ins);
            drive(1'b1, ins);
            do_reset();
        end
        for (int k = 0; k < 400; k++) begin
            drive(1'b1, rnd());
            if (halted) begin
                drive(1'b1, rnd());
                do_reset();
            end
        end
        drive(1'b0, '0);
        final_report();
    end
endmodule : bft_unit_test
